// ===== design/cic_timer.sv
// 16-bit up/down timer with input capture behind an APB slave.
// Assumes bus signals synchronous to clock; registers one word each.
//
// Summary of operation
// RQ1: 16-bit counter seen as two bytes
// RQ2: Low count read copies high into holding
// RQ3: Low count write loads high from holding
// RQ4: Software keeps holding sequence free of interrupts
// RQ5: Three-bit tick select; zero stops counter
// RQ6: Counter readable and writable while stopped
// RQ7: Processor write beats clear or count
// RQ8: Waveform field picks clear, up or down
// RQ9: Overflow flag set per mode, can interrupt
// RQ10: Chosen edge copies count into capture
// RQ11: Capture flag set with the copy
// RQ12: Enabled capture flag interrupts, clears when serviced
// RQ13: Writing one clears flag, zero ignored
// RQ14: Capture low read loads holding register
// RQ15: Capture writable only in capture-top modes
// RQ16: Software writes high byte before low
// RQ17: Trigger from pin or comparator select
// RQ18: Source change may capture; software clears flag
// RQ19: Filter output moves after four agreeing samples
// RQ20: Filter enable adds four clock delay
// RQ21: No captures in capture-top modes
// RQ22: New capture overwrites old value
// RQ23: One holding register for all words
// RQ24: Synchronised input, edge polarity selectable
`timescale 1ns/10ps
`default_nettype none
`include "cic_defs.svh"
module cic_timer (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capPin,
  input  wire logic        compOut,
  input  wire logic        extTickPin,
  input  wire logic        ovfSvc,
  input  wire logic        capSvc,
  output logic             ovfIrq,
  output logic             capIrq
);
  //--------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------
  logic        pready_ff;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  wb;
  // One access strobe per transfer; the wait state makes it single
  assign acc = psel & penable & ~pready_ff;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign wb  = pwdata[7:0];

  logic wrCntL;
  logic wrCapL;
  logic wrFlags;
  assign wrCntL  = wr & (paddr == `CIC_A_CNTL);
  assign wrCapL  = wr & (paddr == `CIC_A_CAPL);
  assign wrFlags = wr & (paddr == `CIC_A_FLAGS);

  //--------------------------------------------------------------
  // Control registers
  //--------------------------------------------------------------
  cic_pkg::cic_ctrla_t ctrlA_ff;
  cic_pkg::cic_ctrlb_t ctrlB_ff;
  logic [1:0]          irqEn_ff;
  logic                cmpSel_ff;
  logic [3:0]          mode;
  assign mode = {ctrlB_ff.modeHi, ctrlA_ff.modeLo};

  // Plain storage, no side effects on write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrlA_ff  <= cic_pkg::cic_ctrla_t'(`CIC_RST_BYTE);
      ctrlB_ff  <= cic_pkg::cic_ctrlb_t'(`CIC_RST_BYTE);
      irqEn_ff  <= 2'h0;
      cmpSel_ff <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `CIC_A_CTRLA:  ctrlA_ff  <= cic_pkg::cic_ctrla_t'(wb);
        `CIC_A_CTRLB:  ctrlB_ff  <= cic_pkg::cic_ctrlb_t'(wb);
        `CIC_A_IRQEN:  irqEn_ff  <= wb[1:0];
        `CIC_A_CMPCTL: cmpSel_ff <= wb[`CIC_B_CMPSEL]; // see RQ17
        default: ;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Mode decode
  //--------------------------------------------------------------
  logic        icrTop;
  logic        dual;
  logic        toTop;
  logic        ovfAtTop;
  logic [15:0] top;
  logic [15:0] cap_ff;
  // Capture-top modes reuse the capture word as the period
  assign icrTop   = (mode == 4'h8) | (mode == 4'hA) |
                    (mode == 4'hC) | (mode == 4'hE);
  assign dual     = (mode >= 4'h1 && mode <= 4'h3) |
                    (mode == 4'h8) | (mode == 4'hA);
  assign toTop    = (mode >= 4'h5 && mode <= 4'h7) |
                    (mode == 4'hC) | (mode == 4'hE);
  assign ovfAtTop = toTop & (mode != 4'hC);

  // Period per mode; unsupported modes run free
  always_comb begin
    case (mode)
      4'h1, 4'h5: top = `CIC_TOP_8;
      4'h2, 4'h6: top = `CIC_TOP_9;
      4'h3, 4'h7: top = `CIC_TOP_10;
      4'h8, 4'hA, 4'hC, 4'hE: top = cap_ff;
      default: top = `CIC_MAX;
    endcase
  end

  //--------------------------------------------------------------
  // Input synchronisers
  //--------------------------------------------------------------
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  // Stage A is read only by stage B
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA_ff <= 3'h0;
      syncB_ff <= 3'h0;
    end else begin
      syncA_ff <= {extTickPin, compOut, capPin}; // see RQ24
      syncB_ff <= syncA_ff;
    end
  end

  //--------------------------------------------------------------
  // Tick generation
  //--------------------------------------------------------------
  logic [9:0] presc_ff;
  logic       extPrev_ff;
  logic       tick;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      presc_ff   <= 10'h000;
      extPrev_ff <= 1'b0;
    end else begin
      presc_ff   <= presc_ff + 10'h001;
      extPrev_ff <= syncB_ff[2];
    end
  end

  // Divided ticks fire when the low prescaler bits are all ones
  always_comb begin
    case (ctrlB_ff.tickSel)
      3'h1: tick = 1'b1;
      3'h2: tick = &presc_ff[2:0];
      3'h3: tick = &presc_ff[5:0];
      3'h4: tick = &presc_ff[7:0];
      3'h5: tick = &presc_ff[9:0];
      3'h6: tick = extPrev_ff & ~syncB_ff[2];
      3'h7: tick = ~extPrev_ff & syncB_ff[2];
      default: tick = 1'b0; // see RQ5
    endcase
  end

  //--------------------------------------------------------------
  // Counter unit
  //--------------------------------------------------------------
  logic [15:0]       cnt_ff;
  logic [7:0]        temp_ff;
  cic_pkg::cic_dir_t dir_ff;
  logic              ovfEv;
  // Write first, then the mode's clear, up or down step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= `CIC_RST_WORD;
      dir_ff <= cic_pkg::CIC_UP;
    end else if (wrCntL) begin
      cnt_ff <= {temp_ff, wb}; // see RQ3 RQ6 RQ7
    end else if (tick) begin
      if (dual) begin
        if (dir_ff == cic_pkg::CIC_UP) begin
          if (cnt_ff >= top) begin
            dir_ff <= cic_pkg::CIC_DOWN;
            cnt_ff <= cnt_ff - 16'h0001; // see RQ8
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end else if (cnt_ff == `CIC_RST_WORD) begin
          dir_ff <= cic_pkg::CIC_UP;
          cnt_ff <= 16'h0001;
        end else begin
          cnt_ff <= cnt_ff - 16'h0001;
        end
      end else if (toTop && cnt_ff >= top) begin
        cnt_ff <= `CIC_RST_WORD; // see RQ8
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // Overflow point: bottom, top or max depending on mode; none in mode 12
  always_comb begin
    ovfEv = 1'b0;
    if (tick && !wrCntL) begin
      if (dual)
        ovfEv = (dir_ff == cic_pkg::CIC_DOWN) &&
                (cnt_ff == `CIC_RST_WORD); // see RQ9
      else if (toTop)
        ovfEv = ovfAtTop && (cnt_ff >= top);
      else
        ovfEv = (cnt_ff == `CIC_MAX);
    end
  end

  //--------------------------------------------------------------
  // Capture path: source, filter, edge
  //--------------------------------------------------------------
  logic       src;
  logic [2:0] filt_ff;
  logic [3:0] filtWin;
  logic       filtOut_ff;
  logic       edgeIn;
  logic       edgePrev_ff;
  logic       capEv;
  // Switching source may look like an edge
  assign src = cmpSel_ff ? syncB_ff[1] : syncB_ff[0]; // see RQ17 RQ18

  // Three stored samples plus the live one; a fourth flop would add a
  // fifth cycle of delay
  assign filtWin = {filt_ff, src};

  // Filter output flips only when four samples agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      filt_ff    <= 3'h0;
      filtOut_ff <= 1'b0;
    end else begin
      filt_ff <= filtWin[2:0];
      if (&filtWin)
        filtOut_ff <= 1'b1; // see RQ19 RQ20
      else if (~|filtWin)
        filtOut_ff <= 1'b0;
    end
  end

  assign edgeIn = ctrlB_ff.filtEn ? filtOut_ff : src;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      edgePrev_ff <= 1'b0;
    else
      edgePrev_ff <= edgeIn;
  end

  // Edge detector blocked while capture word sets the period
  assign capEv = ~icrTop & (ctrlB_ff.edgeRise ?
                 (edgeIn & ~edgePrev_ff) :
                 (~edgeIn & edgePrev_ff)); // see RQ10 RQ21 RQ24

  // Every event overwrites; writes only in capture-top modes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      cap_ff <= `CIC_RST_WORD;
    else if (capEv)
      cap_ff <= cnt_ff; // see RQ10 RQ22
    else if (wrCapL && icrTop)
      cap_ff <= {temp_ff, wb}; // see RQ15
  end

  //--------------------------------------------------------------
  // Shared high-byte holding register
  //--------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      temp_ff <= `CIC_RST_BYTE;
    else if (wr && (paddr == `CIC_A_CNTH || paddr == `CIC_A_CAPH))
      temp_ff <= wb; // see RQ3 RQ23
    else if (rd && paddr == `CIC_A_CNTL)
      temp_ff <= cnt_ff[15:8]; // see RQ2
    else if (rd && paddr == `CIC_A_CAPL)
      temp_ff <= cap_ff[15:8]; // see RQ14
  end

  //--------------------------------------------------------------
  // Flags and interrupt requests
  //--------------------------------------------------------------
  logic ovfFlag_ff;
  logic capFlag_ff;
  logic ovfIrq_ff;
  logic capIrq_ff;
  // Set beats clear from software or service
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovfFlag_ff <= 1'b0;
      capFlag_ff <= 1'b0;
    end else begin
      if (ovfEv)
        ovfFlag_ff <= 1'b1;
      else if (ovfSvc || (wrFlags && wb[`CIC_B_OVF]))
        ovfFlag_ff <= 1'b0;
      if (capEv)
        capFlag_ff <= 1'b1; // see RQ11
      else if (capSvc || (wrFlags && wb[`CIC_B_CAP]))
        capFlag_ff <= 1'b0; // see RQ12 RQ13
    end
  end

  // Requests mirror enabled flags, one cycle later
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovfIrq_ff <= 1'b0;
      capIrq_ff <= 1'b0;
    end else begin
      ovfIrq_ff <= ovfFlag_ff & irqEn_ff[`CIC_B_OVF]; // see RQ9
      capIrq_ff <= capFlag_ff & irqEn_ff[`CIC_B_CAP]; // see RQ12
    end
  end
  assign ovfIrq = ovfIrq_ff;
  assign capIrq = capIrq_ff;

  //--------------------------------------------------------------
  // Read data and response
  //--------------------------------------------------------------
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [7:0]  rdByte;
  logic        mapped;
  // High locations return the holding register
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `CIC_A_CTRLA:  rdByte = ctrlA_ff;
      `CIC_A_CTRLB:  rdByte = ctrlB_ff;
      `CIC_A_CNTL:   rdByte = cnt_ff[7:0]; // see RQ1
      `CIC_A_CNTH:   rdByte = temp_ff;     // see RQ2
      `CIC_A_CAPL:   rdByte = cap_ff[7:0];
      `CIC_A_CAPH:   rdByte = temp_ff;     // see RQ14
      `CIC_A_FLAGS:  rdByte = {6'h00, capFlag_ff, ovfFlag_ff};
      `CIC_A_IRQEN:  rdByte = {6'h00, irqEn_ff};
      `CIC_A_CMPCTL: rdByte = {7'h00, cmpSel_ff};
      default: begin
        rdByte = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // One wait state: answer in the cycle after access begins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~mapped;
      if (rd)
        prdata_ff <= {24'h000000, rdByte};
    end
  end
  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  sequence s_capLowRd;
    rd && paddr == `CIC_A_CAPL;
  endsequence
  sequence s_capSet;
    capFlag_ff && cap_ff == $past(cnt_ff);
  endsequence

  property p_stop;
    @(posedge clock) disable iff (!arst_n)
    (ctrlB_ff.tickSel == 3'h0 && !wrCntL) |=>
      cnt_ff == $past(cnt_ff);
  endproperty
  a_stop: assert property (p_stop) // see RQ5
    else $error("counter moved while stopped");

  property p_wrPrio;
    @(posedge clock) disable iff (!arst_n)
    wrCntL |=> cnt_ff == {$past(temp_ff), $past(wb)};
  endproperty
  a_wrPrio: assert property (p_wrPrio) // see RQ7
    else $error("counter write lost");

  property p_lowRd;
    @(posedge clock) disable iff (!arst_n)
    (rd && paddr == `CIC_A_CNTL) |=>
      temp_ff == $past(cnt_ff[15:8]) ##2 pready_ff == 1'b0;
  endproperty
  a_lowRd: assert property (p_lowRd) // see RQ2
    else $error("holding not loaded on count read");

  property p_capRd;
    @(posedge clock) disable iff (!arst_n)
    s_capLowRd |=> temp_ff == $past(cap_ff[15:8]);
  endproperty
  a_capRd: assert property (p_capRd) // see RQ14
    else $error("holding not loaded on capture read");

  property p_capture;
    @(posedge clock) disable iff (!arst_n)
    capEv |=> s_capSet;
  endproperty
  a_capture: assert property (p_capture) // see RQ11
    else $error("capture flag or value wrong");

  property p_w1c;
    @(posedge clock) disable iff (!arst_n)
    (wrFlags && wb[`CIC_B_CAP] && !capEv) |=> !capFlag_ff;
  endproperty
  a_w1c: assert property (p_w1c) // see RQ13
    else $error("capture flag not cleared");

  property p_w0;
    @(posedge clock) disable iff (!arst_n)
    (wrFlags && !wb[`CIC_B_CAP] && capFlag_ff && !capSvc)
      |=> capFlag_ff;
  endproperty
  a_w0: assert property (p_w0) // see RQ13
    else $error("capture flag cleared by zero");

  property p_noCap;
    @(posedge clock) disable iff (!arst_n)
    (icrTop && !wrCapL) |=>
      cap_ff == $past(cap_ff) && !$rose(capFlag_ff);
  endproperty
  a_noCap: assert property (p_noCap) // see RQ21
    else $error("capture in capture-top mode");

  property p_filt;
    @(posedge clock) disable iff (!arst_n)
    (filtOut_ff != $past(filtOut_ff)) |->
      ($past(filtWin) == 4'hF || $past(filtWin) == 4'h0);
  endproperty
  a_filt: assert property (p_filt) // see RQ19
    else $error("filter moved without agreement");

  property p_ovf;
    @(posedge clock) disable iff (!arst_n)
    (mode == 4'h0 && tick && cnt_ff == `CIC_MAX && !wrCntL)
      |=> ovfFlag_ff && cnt_ff == `CIC_RST_WORD;
  endproperty
  a_ovf: assert property (p_ovf) // see RQ9
    else $error("overflow missed at max");

  property p_capIrq;
    @(posedge clock) disable iff (!arst_n)
    (capFlag_ff && irqEn_ff[`CIC_B_CAP]) |=> capIrq_ff;
  endproperty
  a_capIrq: assert property (p_capIrq) // see RQ12
    else $error("capture request not raised");
endmodule
`default_nettype wire

// ===== design/cic_defs.svh
// Offsets, field positions and reset values of the capture timer.
// Assumes an APB slave with byte addresses, one word per register.
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH
`define CIC_A_CTRLA   8'h00
`define CIC_A_CTRLB   8'h04
`define CIC_A_CNTL    8'h08
`define CIC_A_CNTH    8'h0C
`define CIC_A_CAPL    8'h10
`define CIC_A_CAPH    8'h14
`define CIC_A_FLAGS   8'h18
`define CIC_A_IRQEN   8'h1C
`define CIC_A_CMPCTL  8'h20
`define CIC_B_OVF     0
`define CIC_B_CAP     1
`define CIC_B_CMPSEL  0
`define CIC_RST_BYTE  8'h00
`define CIC_RST_WORD  16'h0000
`define CIC_MAX       16'hFFFF
`define CIC_TOP_8     16'h00FF
`define CIC_TOP_9     16'h01FF
`define CIC_TOP_10    16'h03FF
`define CIC_FILT_N    4
`endif

// ===== design/cic_pkg.sv
// Types shared by the capture timer.
// Assumes the offsets and counts come from cic_defs.svh.
package cic_pkg;
  // Control B layout: filter, edge, waveform high bits, tick select
  typedef struct packed {
    logic       filtEn;
    logic       edgeRise;
    logic       rsvd;
    logic [1:0] modeHi;
    logic [2:0] tickSel;
  } cic_ctrlb_t;
  // Control A: low two waveform bits; the upper six reserved bits are stored and read back too
  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] modeLo;
  } cic_ctrla_t;
  // Count direction of the dual-slope modes
  typedef enum logic {
    CIC_UP   = 1'b0,
    CIC_DOWN = 1'b1
  } cic_dir_t;
endpackage

// ===== bench/cic_cpu_model.sv
// APB master standing in for the processor core of the timer.
// Assumes a slave that answers every transfer with pready.
`timescale 1ns/10ps
`default_nettype none
module cic_cpu_model (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic lastErr;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    lastErr = 1'b0;
  end
  // Request stands until pready is sampled; pwdata is inverted on release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    r       = prdata[7:0];
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    xfer(1'b0, a, 8'h00, r);
  endtask
  // Word tasks never interleave, so nothing disturbs holding
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h04, v[15:8]); // High byte first
    wr(a, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo); // Low byte first
    rd(a + 8'h04, hi);
    v = {hi, lo};
  endtask
endmodule
`default_nettype wire

// ===== bench/counter16_input_capture_tb.sv
// Self-checking bench of the capture timer behind APB.
// Assumes cic_cpu_model drives the bus; pins are driven here.
`timescale 1ns/10ps
`default_nettype none
`include "cic_defs.svh"
module counter16_input_capture_tb;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, byteRd;
  logic [31:0] pwdata, prdata, rngState;
  logic        capPin, compOut, extTickPin, ovfSvc, capSvc, ovfIrq, capIrq;
  logic [15:0] val, got, got2;
  logic [7:0]  modeA [3] = '{8'h00, 8'h01, 8'h01};
  logic [7:0]  modeB [3] = '{8'h00, 8'h08, 8'h00};
  logic [15:0] startV [3] = '{16'hFFF0, 16'h00F0, 16'h00F0};
  logic [15:0] loV [3] = '{16'h0001, 16'h0000, 16'h00C0};
  logic [15:0] hiV [3] = '{16'h0040, 16'h0040, 16'h00FF};
  int          bad_count, n_tests;
  int          expCap;
  cic_timer DUT (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .capPin(capPin),
    .compOut(compOut), .extTickPin(extTickPin), .ovfSvc(ovfSvc),
    .capSvc(capSvc), .ovfIrq(ovfIrq), .capIrq(capIrq));
  cic_cpu_model cpu (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic rnd16(output logic [15:0] v);
    rngState = xorshift(rngState);
    v = rngState[15:0];
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    cpu.rd(a, byteRd);
    chk({8'h00, byteRd}, {8'h00, e});
  endtask
  task automatic rd16Chk(input logic [7:0] a, input logic [15:0] e);
    cpu.rd16(a, got);
    chk(got, e);
  endtask
  // Runs the counter on every clock for a fixed span, then stops it
  task automatic runMode(input logic [7:0] cA, input logic [7:0] cB,
                         input logic [15:0] s, output logic [15:0] c);
    cpu.wr(`CIC_A_CTRLA, cA);
    cpu.wr16(`CIC_A_CNTL, s);
    cpu.wr(`CIC_A_CTRLB, cB | 8'h01);
    repeat (40) @(posedge clock);
    cpu.wr(`CIC_A_CTRLB, cB);
    cpu.rd16(`CIC_A_CNTL, c);
  endtask
  // Same bench timing each call, so only the filter changes the stamp
  task automatic capAt(input logic [7:0] cB, output logic [15:0] c);
    cpu.wr(`CIC_A_CTRLB, cB);
    capPin <= 1'b0;
    repeat (10) @(posedge clock);
    cpu.wr16(`CIC_A_CNTL, 16'h0000);
    capPin <= 1'b1;
    repeat (12) @(posedge clock);
    cpu.wr(`CIC_A_CTRLB, 8'h00);
    cpu.rd16(`CIC_A_CAPL, c);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog well past the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    capPin = 1'b0;
    compOut = 1'b0;
    extTickPin = 1'b0;
    ovfSvc = 1'b0;
    capSvc = 1'b0;
    rngState = 32'h00008A4D;
    bad_count = 0;
    n_tests = 0;
    expCap = 0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rdChk(`CIC_A_CTRLB, 8'h00);
    rnd16(val);
    cpu.wr16(`CIC_A_CNTL, val);
    repeat (5) @(posedge clock);
    rd16Chk(`CIC_A_CNTL, val);
    cpu.rd(`CIC_A_CNTL, byteRd);
    rdChk(`CIC_A_CAPH, val[15:8]);
    cpu.rd(8'hFC, byteRd);
    chk({byteRd, 7'h00, cpu.lastErr}, 16'h0001);
    // Write while ticking lands, then counting goes on from it
    cpu.wr(`CIC_A_CTRLB, 8'h01);
    cpu.wr16(`CIC_A_CNTL, 16'h1234);
    cpu.rd16(`CIC_A_CNTL, got);
    chk({15'h0000, got > 16'h1234 && got < 16'h1240}, 16'h0001);
    // External rising edges step the counter once each
    cpu.wr(`CIC_A_CTRLB, 8'h07);
    cpu.wr16(`CIC_A_CNTL, 16'h0000);
    repeat (3) begin
      extTickPin <= 1'b1;
      repeat (4) @(posedge clock);
      extTickPin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    cpu.wr(`CIC_A_CTRLB, 8'h00);
    rd16Chk(`CIC_A_CNTL, 16'h0003);
    // Divide-by-eight tap: 84 clock edges give 10 or 11 steps
    cpu.wr16(`CIC_A_CNTL, 16'h0000);
    cpu.wr(`CIC_A_CTRLB, 8'h02);
    repeat (80) @(posedge clock);
    cpu.wr(`CIC_A_CTRLB, 8'h00);
    cpu.rd16(`CIC_A_CNTL, got);
    chk({15'h0000, got >= 16'h000A && got <= 16'h000B}, 16'h0001);
    cpu.wr(`CIC_A_IRQEN, 8'h03);
    for (int i = 0; i < 3; i++) begin
      runMode(modeA[i], modeB[i], startV[i], got);
      chk({15'h0000, got >= loV[i] && got <= hiV[i]}, 16'h0001);
    end
    rdChk(`CIC_A_FLAGS, 8'h01);
    chk({15'h0000, ovfIrq}, 16'h0001);
    cpu.wr(`CIC_A_FLAGS, 8'h00);
    rdChk(`CIC_A_FLAGS, 8'h01);
    cpu.wr(`CIC_A_FLAGS, 8'h01);
    rdChk(`CIC_A_FLAGS, 8'h00);
    // Service pulse clears a fresh overflow and drops its request
    runMode(8'h00, 8'h00, 16'hFFF0, got);
    chk({15'h0000, ovfIrq}, 16'h0001);
    ovfSvc <= 1'b1;
    @(posedge clock);
    ovfSvc <= 1'b0;
    repeat (3) @(posedge clock);
    chk({15'h0000, ovfIrq}, 16'h0000);
    rdChk(`CIC_A_FLAGS, 8'h00);
    // Rising edges capture, falling ones do not, newest value wins
    cpu.wr(`CIC_A_CTRLA, 8'h00);
    cpu.wr(`CIC_A_CTRLB, 8'h40);
    for (int i = 0; i < 3; i++) begin
      rnd16(val);
      cpu.wr16(`CIC_A_CNTL, val);
      capPin <= 1'b1;
      expCap = int'(val);
      repeat (8) @(posedge clock);
      rd16Chk(`CIC_A_CAPL, expCap[15:0]);
      cpu.wr16(`CIC_A_CNTL, ~val);
      capPin <= 1'b0;
      repeat (8) @(posedge clock);
      rd16Chk(`CIC_A_CAPL, expCap[15:0]);
    end
    rdChk(`CIC_A_FLAGS, 8'h02);
    chk({15'h0000, capIrq}, 16'h0001);
    capSvc <= 1'b1;
    @(posedge clock);
    capSvc <= 1'b0;
    repeat (3) @(posedge clock);
    chk({15'h0000, capIrq}, 16'h0000);
    rdChk(`CIC_A_FLAGS, 8'h00);
    // Filter: short pulse ignored, settled edge four cycles later
    cpu.wr(`CIC_A_CTRLB, 8'hC0);
    capPin <= 1'b1;
    repeat (3) @(posedge clock);
    capPin <= 1'b0;
    repeat (10) @(posedge clock);
    rdChk(`CIC_A_FLAGS, 8'h00);
    capAt(8'h41, got2);
    capAt(8'hC1, got);
    chk(got - got2, 16'h0004);
    // Comparator source: pin edges no longer count
    cpu.wr(`CIC_A_CTRLB, 8'h40);
    capPin <= 1'b0;
    cpu.wr(`CIC_A_CMPCTL, 8'h01);
    cpu.wr(`CIC_A_FLAGS, 8'h02);
    rnd16(val);
    cpu.wr16(`CIC_A_CNTL, val);
    capPin <= 1'b1;
    repeat (8) @(posedge clock);
    rdChk(`CIC_A_FLAGS, 8'h00);
    compOut <= 1'b1;
    repeat (8) @(posedge clock);
    rd16Chk(`CIC_A_CAPL, val);
    cpu.wr(`CIC_A_CMPCTL, 8'h00);
    // Mode 12 takes the top value and blocks captures
    cpu.wr(`CIC_A_CTRLB, 8'h58); // Mode set before top
    rnd16(val);
    cpu.wr16(`CIC_A_CAPL, val);
    rd16Chk(`CIC_A_CAPL, val);
    capPin <= 1'b0;
    repeat (8) @(posedge clock);
    cpu.wr(`CIC_A_FLAGS, 8'h02);
    capPin <= 1'b1;
    repeat (8) @(posedge clock);
    rdChk(`CIC_A_FLAGS, 8'h00);
    rd16Chk(`CIC_A_CAPL, val);
    cpu.wr(`CIC_A_CTRLB, 8'h40);
    cpu.wr16(`CIC_A_CAPL, ~val);
    rd16Chk(`CIC_A_CAPL, val);
    end_sim();
  end
endmodule
`default_nettype wire
